// *** pkg/iosc_pkg.sv ***
// Package with constants, types and states of the internal oscillator select and clock switch block.
// ****************************************************************************
// ****************************************************************************
package iosc_pkg;

   // Bus geometry and register offsets.
   localparam int          ADDR_W        = 4;
   localparam logic [3:0]  OFS_TUNING    = 4'h0;
   localparam logic [3:0]  OFS_CONTROL   = 4'h4;

   // Field layout.
   localparam int          TRIM_W        = 5;
   localparam int          CTL_SEL_BIT   = 0;
   localparam int          CTL_LF_BIT    = 1;
   localparam int          CTL_HF_BIT    = 2;
   localparam int          CTL_TOUT_BIT  = 3;
   localparam int          CTL_FSEL_LSB  = 4;

   // Values after reset, and the low and undivided high tap codes.
   localparam logic [4:0]  TRIM_RST      = 5'h00;
   localparam logic [2:0]  FSEL_RST      = 3'b110;
   localparam logic [2:0]  FSEL_LF       = 3'b000;
   localparam logic [2:0]  FSEL_HF_FULL  = 3'b111;

   // Configured oscillator modes that use a crystal.
   localparam logic [2:0]  MODE_LO_GAIN  = 3'b000;
   localparam logic [2:0]  MODE_MID_GAIN = 3'b001;
   localparam logic [2:0]  MODE_HI_GAIN  = 3'b010;

   // Timing, each time in its own unit and its cycle count derived from the clock rate.
   localparam int          CLK_MHZ       = 50;
   localparam int          HF_WARM_NS    = 1000;
   localparam int          LF_WARM_NS    = 2000;
   localparam int          TRIM_STEP_NS  = 1000;
   localparam int          HF_WARM_CYC   = (HF_WARM_NS * CLK_MHZ + 999) / 1000;
   localparam int          LF_WARM_CYC   = (LF_WARM_NS * CLK_MHZ + 999) / 1000;
   localparam int          TRIM_STEP_CYC = (TRIM_STEP_NS * CLK_MHZ + 999) / 1000;
   localparam int          STUP_COUNT    = 1024;
   localparam int          CNT_W         = 12;

   // Configuration word fields that reach this block.
   typedef struct packed {
      logic [2:0] cfg_osc_mode;
      logic       two_speed_enable;
      logic       powerup_timer_en;
      logic       watchdog_timer_en;
      logic       failsafe_monitor_en;
   } iosc_cfg_t;

   // Controls driven toward the analog oscillator cells.
   typedef struct packed {
      logic             high_freq_osc_en;
      logic             low_freq_osc_en;
      logic [TRIM_W-1:0] trim_code;
   } iosc_osc_ctl_t;

   // Switch sequencer, Gray coded along its main path; the IDLE to FALL and WARM to HOLD shortcuts change both bits.
   typedef enum logic [1:0] {
      SW_IDLE = 2'b00,
      SW_WARM = 2'b01,
      SW_FALL = 2'b11,
      SW_HOLD = 2'b10
   } iosc_sw_state_t;

endpackage

// *** rtl/iosc_postscaler.sv ***
// Postscaler and tap multiplexer for the internal oscillators.
`timescale 1ns/1ns
module iosc_postscaler
(
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Oscillator levels, synchronous to clk.
   input  wire logic       hf_level,
   input  wire logic       lf_level,
   // Tap selects for the connected and the pending source.
   input  wire logic [2:0] sel_cur,
   input  wire logic [2:0] sel_new,
   // Selected tap levels.
   output logic            lvl_cur,
   output logic            lvl_new
);
   import iosc_pkg::*;

   logic       hf_prev_reg;
   logic [5:0] div_reg;
   logic [7:0] taps;

   // The divider advances on each rising edge of the high-frequency oscillator.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hf_prev_reg <= 1'b0;
         div_reg     <= 6'h00;
      end
      else
      begin
         hf_prev_reg <= hf_level;
         if (hf_level && !hf_prev_reg)
            div_reg <= div_reg + 6'h01;
      end
   end

   // Code 000 is the low oscillator and 111 the undivided high oscillator.
   assign taps[0] = lf_level;
   assign taps[7] = hf_level;

   // Each lower code down to 001 halves the frequency once more.
   genvar k;
   generate
      for (k = 1; k < 7; k++)
      begin : g_tap
         assign taps[k] = div_reg[6-k];
      end
   endgenerate

   // Registered tap outputs keep the clock path free of decode glitches.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lvl_cur <= 1'b0;
         lvl_new <= 1'b0;
      end
      else
      begin
         lvl_cur <= taps[sel_cur];
         lvl_new <= taps[sel_new];
      end
   end

endmodule

// *** rtl/iosc_clock_switch.sv ***
// Internal oscillator selection, trim, glitch-free internal tap switch and direct system clock select, with its register slave.
//
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
module iosc_clock_switch
(
   // Clock and reset.
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   // Avalon-MM slave.
   input  wire logic [iosc_pkg::ADDR_W-1:0]  avs_address,
   input  wire logic                         avs_read,
   input  wire logic                         avs_write,
   input  wire logic [3:0]                   avs_byteenable,
   input  wire logic [31:0]                  avs_writedata,
   output logic [31:0]                       avs_readdata,
   output logic                              avs_waitrequest,
   // Configuration word fields.
   input  wire iosc_pkg::iosc_cfg_t          cfg,
   // Oscillator levels, synchronous to clk.
   input  wire logic                         hf_osc_level,
   input  wire logic                         lf_osc_level,
   input  wire logic                         ext_clk_level,
   // Oscillator cell controls.
   output iosc_pkg::iosc_osc_ctl_t           osc_ctl,
   // Clock outputs as levels.
   output logic                              int_clk_out,
   output logic                              sys_clk_out,
   output logic                              lf_timebase
);
   import iosc_pkg::*;

   // ****************************************************************************
   // Declarations
   // ****************************************************************************
   logic [TRIM_W-1:0]  trim_reg;
   logic [TRIM_W-1:0]  trim_applied_reg;
   logic [CNT_W-1:0]   trim_cnt_reg;
   logic [2:0]         fsel_reg;
   logic               sel_reg;
   logic [2:0]         cur_sel_reg;
   logic [2:0]         tgt_reg;
   iosc_sw_state_t     state_reg;
   iosc_sw_state_t     state_next;
   logic               hf_flag_reg;
   logic               lf_flag_reg;
   logic               cur_prev_reg;
   logic               new_prev_reg;
   logic               int_clk_reg;
   logic               sys_clk_reg;
   logic               ext_prev_reg;
   logic [CNT_W-1:0]   stup_cnt_reg;
   logic               stup_done_reg;
   logic               tout_status;
   logic               ack_reg;
   logic [31:0]        rdata_reg;
   logic [CNT_W-1:0]   warm_cnt_reg [2];
   logic [1:0]         osc_ready;
   logic [1:0]         osc_en;
   logic               lvl_cur;
   logic               lvl_new;

   // ****************************************************************************
   // Register bus
   // ****************************************************************************

   // One wait state on every access; the answer comes at the second edge.
   wire bus_req    = avs_read | avs_write;
   wire bus_done   = bus_req & ack_reg;
   wire hit_tune   = (avs_address == OFS_TUNING);
   wire hit_ctl    = (avs_address == OFS_CONTROL);
   wire wr_tune    = avs_write & bus_done & hit_tune & avs_byteenable[0];
   wire wr_ctl     = avs_write & bus_done & hit_ctl & avs_byteenable[0];

   assign avs_waitrequest = bus_req & ~ack_reg;

   // Upper tuning bits are not stored and read back as zero.
   wire [31:0] rd_tune = {27'h000_0000, trim_reg};
   wire [31:0] rd_ctl  = {25'h000_0000, fsel_reg, tout_status,
                          hf_flag_reg, lf_flag_reg, sel_reg};
   wire [31:0] rd_mux  = hit_tune ? rd_tune : (hit_ctl ? rd_ctl : 32'h0000_0000);

   // Acknowledge toggles, so a held request is answered every second cycle.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ack_reg <= 1'b0;
      else
         ack_reg <= bus_req & ~ack_reg;
   end

   // Read data is captured at the first edge and stands through the answer cycle.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata_reg <= 32'h0000_0000;
      else if (avs_read & ~ack_reg)
         rdata_reg <= rd_mux;
   end

   assign avs_readdata = rdata_reg;

   // ****************************************************************************
   // Software controls
   // ****************************************************************************

   // Trim target, frequency code and select bit; only software writes them.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         trim_reg <= TRIM_RST;
         fsel_reg <= FSEL_RST;
         sel_reg  <= 1'b0;
      end
      else
      begin
         if (wr_tune)
            trim_reg <= avs_writedata[TRIM_W-1:0];
         if (wr_ctl)
         begin
            fsel_reg <= avs_writedata[CTL_FSEL_LSB +: 3];
            sel_reg  <= avs_writedata[CTL_SEL_BIT];
         end
      end
   end

   // ****************************************************************************
   // Trim slew
   // ****************************************************************************

   // The trim reaching the oscillator walks one step per interval toward the target,
   // so the frequency drifts rather than jumps; nothing reports arrival.
   wire trim_tick = (trim_cnt_reg == CNT_W'(TRIM_STEP_CYC - 1));
   wire trim_up   = $signed(trim_reg) > $signed(trim_applied_reg);
   wire trim_dn   = $signed(trim_reg) < $signed(trim_applied_reg);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         trim_cnt_reg     <= '0;
         trim_applied_reg <= TRIM_RST;
      end
      else
      begin
         trim_cnt_reg <= trim_tick ? '0 : trim_cnt_reg + CNT_W'(1);
         if (trim_tick && trim_up)
            trim_applied_reg <= trim_applied_reg + 5'h01;
         else if (trim_tick && trim_dn)
            trim_applied_reg <= trim_applied_reg - 5'h01;
      end
   end

   // ****************************************************************************
   // External source and start-up timer
   // ****************************************************************************

   wire crystal_mode = (cfg.cfg_osc_mode == MODE_LO_GAIN) | (cfg.cfg_osc_mode == MODE_MID_GAIN)
                     | (cfg.cfg_osc_mode == MODE_HI_GAIN);

   // Crystal modes count external rising edges before the source is trusted.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ext_prev_reg <= 1'b0;
         stup_cnt_reg  <= '0;
         stup_done_reg <= 1'b0;
      end
      else
      begin
         ext_prev_reg <= ext_clk_level;
         if (ext_clk_level && !ext_prev_reg && !stup_done_reg)
         begin
            stup_cnt_reg <= stup_cnt_reg + CNT_W'(1);
            if (stup_cnt_reg == CNT_W'(STUP_COUNT - 1))
               stup_done_reg <= 1'b1;
         end
      end
   end

   // External source ready: at once for clock and RC modes, after the timer otherwise.
   wire ext_ready = ~crystal_mode | stup_done_reg;

   // A plain net rather than a function, so the read mux sees every change of its inputs.
   assign tout_status = ~sel_reg & ext_ready;

   // Two-speed start-up runs internally until the crystal is ready, select bit untouched.
   wire two_speed_run = cfg.two_speed_enable & crystal_mode & ~stup_done_reg;
   wire int_active    = sel_reg | two_speed_run;

   // ****************************************************************************
   // Oscillator enables and warm-up
   // ****************************************************************************

   wire fsel_lf  = (fsel_reg == FSEL_LF);
   wire cur_lf   = (cur_sel_reg == FSEL_LF);
   wire sw_busy  = (state_reg != SW_IDLE);
   wire timers   = cfg.powerup_timer_en | cfg.watchdog_timer_en | cfg.failsafe_monitor_en;

   // Index 0 is the high oscillator, index 1 the low one.
   assign osc_en[0] = (~fsel_lf & (sel_reg | cfg.two_speed_enable))
                    | (int_active & ~cur_lf)
                    | (sw_busy & (tgt_reg != FSEL_LF));
   // Once connected to a high tap the low oscillator drops out unless a timer needs it.
   assign osc_en[1] = (fsel_lf & (sel_reg | cfg.two_speed_enable))
                    | timers
                    | (int_active & cur_lf)
                    | (sw_busy & (tgt_reg == FSEL_LF));

   // Warm-up counters per oscillator; ready once the start-up time has passed.
   genvar i;
   generate
      for (i = 0; i < 2; i++)
      begin : g_warm
         localparam logic [CNT_W-1:0] WARM = CNT_W'(i == 0 ? HF_WARM_CYC : LF_WARM_CYC);

         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               warm_cnt_reg[i] <= '0;
            else if (!osc_en[i])
               warm_cnt_reg[i] <= '0;
            else if (warm_cnt_reg[i] != WARM)
               warm_cnt_reg[i] <= warm_cnt_reg[i] + CNT_W'(1);
         end

         assign osc_ready[i] = (warm_cnt_reg[i] == WARM);
      end
   endgenerate

   assign osc_ctl.high_freq_osc_en = osc_en[0];
   assign osc_ctl.low_freq_osc_en  = osc_en[1];
   assign osc_ctl.trim_code        = trim_applied_reg;

   // The timers see the low oscillator whatever the system clock does.
   assign lf_timebase = lf_osc_level & osc_ready[1];

   // ****************************************************************************
   // Tap selection
   // ****************************************************************************

   iosc_postscaler iosc_postscaler_inst
   (
      .clk      (clk),
      .rst_n    (rst_n),
      .hf_level (hf_osc_level),
      .lf_level (lf_osc_level),
      .sel_cur  (cur_sel_reg),
      .sel_new  (tgt_reg),
      .lvl_cur  (lvl_cur),
      .lvl_new  (lvl_new)
   );

   // ****************************************************************************
   // Switch sequencer
   // ****************************************************************************

   wire tgt_lf    = (tgt_reg == FSEL_LF);
   wire tgt_ready = tgt_lf ? osc_ready[1] : osc_ready[0];
   wire cur_ready = cur_lf ? osc_ready[1] : osc_ready[0];
   wire cur_fall  = cur_prev_reg & ~lvl_cur;
   wire new_rise  = lvl_new & ~new_prev_reg;
   wire connect   = (state_reg == SW_HOLD) & new_rise;
   // Between two high taps the oscillator is already running, so no warm-up wait.
   wire hf_to_hf  = ~fsel_lf & ~cur_lf & osc_ready[0];

   // A silent current clock never falls, so a stopped source skips that wait.
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         SW_IDLE:
            if (fsel_reg != cur_sel_reg)
               state_next = hf_to_hf ? SW_FALL : SW_WARM;
         SW_WARM:
            if (tgt_ready)
               state_next = cur_ready ? SW_FALL : SW_HOLD;
         SW_FALL:
            if (cur_fall || !cur_ready)
               state_next = SW_HOLD;
         SW_HOLD:
            if (new_rise)
               state_next = SW_IDLE;
      endcase
   end

   // Target is frozen for the whole switch; a later code change starts a fresh switch.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg    <= SW_IDLE;
         tgt_reg      <= FSEL_RST;
         cur_sel_reg  <= FSEL_RST;
         cur_prev_reg <= 1'b0;
         new_prev_reg <= 1'b0;
      end
      else
      begin
         state_reg    <= state_next;
         cur_prev_reg <= lvl_cur;
         new_prev_reg <= lvl_new;
         if (state_reg == SW_IDLE)
            tgt_reg <= fsel_reg;
         if (connect)
            cur_sel_reg <= tgt_reg;
      end
   end

   // Stable flags refresh at connection and fall at once when an oscillator stops.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hf_flag_reg <= 1'b0;
         lf_flag_reg <= 1'b0;
      end
      else
      begin
         if (connect || !osc_ready[0] || (state_reg == SW_IDLE && osc_ready[0]))
            hf_flag_reg <= osc_ready[0];
         if (connect || !osc_ready[1] || (state_reg == SW_IDLE && osc_ready[1]))
            lf_flag_reg <= osc_ready[1];
      end
   end

   // ****************************************************************************
   // Clock outputs
   // ****************************************************************************

   // The internal clock is held low while waiting for the new clock to rise.
   wire int_clk_next = (state_reg == SW_HOLD) ? 1'b0 : lvl_cur;
   // Select bit 0 follows the configured source, 1 the internal tap; two-speed overrides.
   wire sys_clk_next = int_active ? int_clk_reg
                     : (ext_ready ? ext_clk_level : 1'b0);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         int_clk_reg <= 1'b0;
         sys_clk_reg <= 1'b0;
      end
      else
      begin
         int_clk_reg <= int_clk_next;
         sys_clk_reg <= sys_clk_next;
      end
   end

   assign int_clk_out = int_clk_reg;
   assign sys_clk_out = sys_clk_reg;

endmodule

// *** bench/iosc_clock_switch_asserts.sv ***
// Checker of bus handshake, trim slew and low-frequency timebase of the clock switch.
`timescale 1ns/1ns
module iosc_clock_switch_asserts
   import iosc_pkg::*;
(
   // Clock and reset.
   input wire logic           clk,
   input wire logic           rst_n,
   // Register bus.
   input wire logic [3:0]     avs_address,
   input wire logic           avs_read,
   input wire logic           avs_write,
   input wire logic [31:0]    avs_readdata,
   input wire logic           avs_waitrequest,
   // Oscillator side.
   input wire iosc_cfg_t      cfg,
   input wire logic           lf_osc_level,
   input wire iosc_osc_ctl_t  osc_ctl,
   input wire logic           lf_timebase
);
   // ****
   // Properties
   // ****
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // A request is pending while either strobe is high.
   wire req = avs_read | avs_write;
   property p_wait_first; req && !$past(req) |-> avs_waitrequest; endproperty
   a_wait_first: assert property (p_wait_first) else $error("no wait state on new request");
   property p_one_wait; req && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_one_wait: assert property (p_one_wait) else $error("more than one wait state");
   property p_no_req; !req |-> !avs_waitrequest; endproperty
   a_no_req: assert property (p_no_req) else $error("wait state without request");
   property p_tune_zero; avs_read && !avs_waitrequest && avs_address == OFS_TUNING |-> avs_readdata[31:5] == '0;
   endproperty
   a_tune_zero: assert property (p_tune_zero) else $error("tuning upper bits not zero");
   property p_lf_timers;
      cfg.powerup_timer_en || cfg.watchdog_timer_en || cfg.failsafe_monitor_en |-> osc_ctl.low_freq_osc_en;
   endproperty
   a_lf_timers: assert property (p_lf_timers) else $error("low oscillator off with timer on");
   property p_timebase; lf_timebase |-> lf_osc_level; endproperty
   a_timebase: assert property (p_timebase) else $error("timebase not from low oscillator");
   // The trim must creep one step at a time, never jump to the target.
   property p_trim_step;
      $changed(osc_ctl.trim_code) |-> 5'(osc_ctl.trim_code - $past(osc_ctl.trim_code)) inside {5'h01, 5'h1F};
   endproperty
   a_trim_step: assert property (p_trim_step) else $error("trim moved more than one step");
   property p_trim_hold; $changed(osc_ctl.trim_code) |=> $stable(osc_ctl.trim_code)[*8]; endproperty
   a_trim_hold: assert property (p_trim_hold) else $error("trim stepped too fast");
endmodule
bind iosc_clock_switch iosc_clock_switch_asserts iosc_clock_switch_asserts_inst (.clk, .rst_n, .avs_address,
   .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .cfg, .lf_osc_level, .osc_ctl, .lf_timebase);

// *** bench/iosc_clock_switch_test.sv ***
// Self-checking bench of the internal oscillator select and clock switch.
`timescale 1ns/1ns
module iosc_clock_switch_test;
   import iosc_pkg::*;
   // ****
   // Stimulus and wiring
   // ****
   logic          clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, wreq, last, last_int;
   logic          hf = 1'b0, lf = 1'b0, ext = 1'b0, int_clk, sys_clk, lf_tb;
   logic [3:0]    addr = 4'h0, be = 4'h0;
   logic [31:0]   wdata = 32'h0000_0000, rdata, rv, cyc = 32'h0000_0000;
   iosc_cfg_t     cfg = '{3'h3, 1'b0, 1'b0, 1'b1, 1'b0};
   iosc_osc_ctl_t octl;
   int            fail_count = 0, checked = 0, n, ni, i, e;
   iosc_clock_switch iosc_clock_switch_inst (.clk(clk), .rst_n(rst_n), .avs_address(addr), .avs_read(rd),
      .avs_write(wr), .avs_byteenable(be), .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wreq),
      .cfg(cfg), .hf_osc_level(hf), .lf_osc_level(lf), .ext_clk_level(ext), .osc_ctl(octl),
      .int_clk_out(int_clk), .sys_clk_out(sys_clk), .lf_timebase(lf_tb));
   always #10 clk = ~clk;
   // Oscillator levels with periods of 2, 4 and 16 cycles; internal ones run only while enabled.
   // The counter also guards against a hang.
   always @(posedge clk)
   begin
      cyc <= cyc + 32'h0000_0001;
      hf <= cyc[0] & octl.high_freq_osc_en;
      ext <= cyc[1];
      lf <= cyc[3] & octl.low_freq_osc_en;
      if (cyc == 32'h0000_4E20)
      begin
         fail_count++;
         close_out();
      end
   end
   // One bus access; the request stands until waitrequest is seen low at a rising edge, where data is taken.
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
      @(posedge clk);
      rd <= ~w; wr <= w; addr <= a; wdata <= d; be <= b;
      do @(posedge clk); while (wreq !== 1'b0);
      rv = rdata;
      rd <= 1'b0; wr <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Counts system clock rises, and internal clock rises when asked; one rise of slack covers the phase.
   task automatic rises(input int cyc_n, input int ex, input logic with_int);
      n = 0;
      ni = 0;
      repeat (cyc_n)
      begin
         @(negedge clk);
         if (sys_clk === 1'b1 && last === 1'b0) n++;
         if (int_clk === 1'b1 && last_int === 1'b0) ni++;
         last = sys_clk;
         last_int = int_clk;
      end
      if (n == ex - 1 || n == ex + 1) n = ex;
      if (ni == ex - 1 || ni == ex + 1) ni = ex;
      chk(32'(n), 32'(ex));
      if (with_int) chk(32'(ni), 32'(ex));
   endtask
   task automatic close_out();
      $display("Mismatches %0d, comparisons %0d", fail_count, checked);
      if (fail_count == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Main sequence.
   initial
   begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, OFS_CONTROL, 32'h0000_0000, 4'hF); chk(rv & 32'hFFFF_FFF9, 32'h0000_0068);
      bus(1'b0, OFS_TUNING, 32'h0000_0000, 4'hF); chk(rv, 32'h0000_0000);
      bus(1'b1, 4'h8, 32'hFFFF_FFFF, 4'hF);
      bus(1'b0, 4'h8, 32'h0000_0000, 4'hF); chk(rv, 32'h0000_0000);
      bus(1'b1, OFS_TUNING, 32'hFFFF_FFFF, 4'hF);
      bus(1'b0, OFS_TUNING, 32'h0000_0000, 4'hF); chk(rv, 32'h0000_001F);
      bus(1'b1, OFS_TUNING, 32'h0000_000F, 4'hF);
      bus(1'b1, OFS_TUNING, 32'h0000_0003, 4'h0);
      bus(1'b0, OFS_TUNING, 32'h0000_0000, 4'hF); chk(rv, 32'h0000_000F);
      repeat (1000) @(posedge clk);
      chk(32'(octl.trim_code), 32'h0000_000F);
      // Every internal tap, fastest first, ending on the low oscillator.
      for (i = 7; i >= 0; i--)
      begin
         bus(1'b1, OFS_CONTROL, 32'(i * 16 + 1), 4'hF);
         repeat (300) @(posedge clk);
         e = (i == 0) ? 16 : 128 >> (7 - i);
         rises(256, e, 1'b1);
      end
      chk(32'(octl.high_freq_osc_en), 32'h0000_0000);
      chk(32'(lf_tb), 32'(lf));
      bus(1'b0, OFS_CONTROL, 32'h0000_0000, 4'hF); chk(rv & 32'h0000_007F, 32'h0000_0003);
      cfg.watchdog_timer_en <= 1'b0;
      bus(1'b1, OFS_CONTROL, 32'h0000_0071, 4'hF);
      repeat (300) @(posedge clk);
      chk(32'(octl.low_freq_osc_en), 32'h0000_0000);
      chk(32'(lf_tb), 32'h0000_0000);
      bus(1'b0, OFS_CONTROL, 32'h0000_0000, 4'hF); chk(rv & 32'h0000_007F, 32'h0000_0075);
      bus(1'b1, OFS_CONTROL, 32'h0000_0070, 4'hF);
      repeat (300) @(posedge clk);
      rises(256, 64, 1'b0);
      bus(1'b0, OFS_CONTROL, 32'h0000_0000, 4'hF); chk(rv & 32'h0000_0079, 32'h0000_0078);
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, OFS_CONTROL, 32'h0000_0000, 4'hF); chk(rv & 32'hFFFF_FFF9, 32'h0000_0068);
      // Crystal mode with two-speed start-up runs internally until the start-up timer expires.
      cfg.cfg_osc_mode <= MODE_MID_GAIN;
      cfg.two_speed_enable <= 1'b1;
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, OFS_CONTROL, 32'h0000_0000, 4'hF); chk(rv & 32'h0000_0079, 32'h0000_0060);
      rises(256, 64, 1'b1);
      repeat (4000) @(posedge clk);
      bus(1'b0, OFS_CONTROL, 32'h0000_0000, 4'hF); chk(rv & 32'h0000_0079, 32'h0000_0068);
      rises(256, 64, 1'b0);
      close_out();
   end
endmodule
